/* src/dag_pkg.sv */
// Constants, types and decode helpers for the data address generator
package dag_pkg;

  localparam int          NUM_PTR        = 3;
  // Pointer n block starts at PTR_BASE0 - n*PTR_STRIDE
  localparam logic [11:0] PTR_BASE0      = 12'hfe9;
  localparam logic [11:0] PTR_STRIDE     = 12'h008;
  localparam logic [2:0]  OFS_LOW        = 3'h0;
  localparam logic [2:0]  OFS_HIGH       = 3'h1;
  localparam logic [2:0]  OFS_INDEXED_BY_ACCUMULATOR_OPERAND      = 3'h2;
  localparam logic [2:0]  OFS_POSTDEC    = 3'h4;
  localparam logic [2:0]  OFS_POSTINC    = 3'h5;
  localparam logic [2:0]  OFS_INDIRECT_OPERAND       = 3'h6;
  localparam logic [11:0] IND_OPERAND_1  = 12'hfe7;
  localparam logic [11:0] BSR_ADDR       = 12'hfe0;
  localparam logic [7:0]  ACCESS_SPLIT   = 8'h80;
  localparam logic [3:0]  ACCESS_LO_BANK = 4'h0;
  localparam logic [3:0]  ACCESS_HI_BANK = 4'hf;
  localparam int          D_BIT          = 9;
  localparam int          A_BIT          = 8;
  localparam logic [11:0] PTR_RST        = 12'h000;
  localparam logic [3:0]  BSR_RST        = 4'h0;
  localparam logic [7:0]  ZERO_BYTE      = 8'h00;

  typedef enum logic [2:0] {
    CLS_INHERENT,
    CLS_LITERAL,
    CLS_BRANCH,
    CLS_BYTE,
    CLS_BIT,
    CLS_FULL_MOVE
  } dag_cls_e;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic       last;
    logic       implicit_acc;
    dag_cls_e   cls;
    logic [15:0] opcode;
    logic [15:0] ext;
    logic [7:0] acc;
    logic [7:0] wdata;
  } dag_req_s;

  typedef struct packed {
    logic       hit;
    logic [1:0] idx;
    logic [2:0] ofs;
  } dag_hit_s;

  // Which pointer block an address falls in, and where inside it
  function automatic dag_hit_s dag_match(input logic [11:0] addr);
    dag_hit_s    h;
    logic [11:0] diff;
    h = '0;
    diff = 12'h000;
    for (int n = 0; n < NUM_PTR; n++) begin
      diff = addr - (PTR_BASE0 - PTR_STRIDE * 12'(n));
      if (diff <= {9'h000, OFS_INDIRECT_OPERAND}) begin
        h.hit = 1'b1;
        h.idx = 2'(n);
        h.ofs = diff[2:0];
      end
    end
    return h;
  endfunction : dag_match

  function automatic logic dag_virtual(input dag_hit_s h);
    return h.hit && (h.ofs >= OFS_INDEXED_BY_ACCUMULATOR_OPERAND);
  endfunction : dag_virtual

endpackage : dag_pkg

/* src/dag_core.sv */
// Operand address generation, pointer registers and result routing
`timescale 1ns/100ps
module dag_core
  import dag_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  input  wire dag_req_s    req_in,
  input  wire logic [7:0]  mem_rdata_in,
  output logic [11:0]      mem_addr_out,
  output logic             mem_rd_out,
  output logic             mem_wr_out,
  output logic [7:0]       mem_wdata_out,
  output logic             acc_wr_out,
  output logic [7:0]       acc_wdata_out,
  output logic             literal_valid_out,
  output logic [7:0]       literal_out,
  output logic             target_valid_out,
  output logic [19:0]      target_out,
  output logic             global_op_out,
  output logic             rd_valid_out,
  output logic [7:0]       rd_data_out
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  logic [11:0] ptr_q [NUM_PTR];
  logic [3:0]  bsr_q;
  logic        rsel_mem_q;
  logic        rsel_int_q;
  logic [7:0]  int_data_q;

  logic        mem_cls;
  logic [11:0] eff1;
  dag_hit_s    h1;
  dag_hit_s    h2;
  logic        is_ind;
  logic [11:0] ptr_sel;
  logic [11:0] eff2;
  logic        nested;
  logic        self_wr;
  logic        ptr_byte;
  logic        internal;
  logic        to_acc;
  logic        to_file;
  logic        file_wr;
  logic        rd_req;
  logic [7:0]  int_rdata;
  logic        ptr_wr_lo [NUM_PTR];
  logic        ptr_wr_hi [NUM_PTR];
  logic        ptr_inc   [NUM_PTR];
  logic        ptr_dec   [NUM_PTR];

  ////////////////////////////////////////////////////////////////////////////
  // Address resolution

  always_comb begin
    mem_cls = req_in.cls inside {CLS_BYTE, CLS_BIT, CLS_FULL_MOVE};
    eff1 = 12'h000;
    case (req_in.cls)
      CLS_BYTE, CLS_BIT: begin
        if (req_in.opcode[A_BIT]) begin
          eff1 = {bsr_q, req_in.opcode[7:0]};
        end else if (req_in.opcode[7:0] < ACCESS_SPLIT) begin
          eff1 = {ACCESS_LO_BANK, req_in.opcode[7:0]};
        end else begin
          eff1 = {ACCESS_HI_BANK, req_in.opcode[7:0]};
        end
      end
      CLS_FULL_MOVE: begin
        // Both words hold whole addresses, bank select never enters
        eff1 = req_in.write ? req_in.ext[11:0]
                            : req_in.opcode[11:0];
      end
      default: begin
        eff1 = 12'h000;
      end
    endcase
  end

  always_comb begin
    h1 = dag_match(eff1);
    is_ind = req_in.valid && mem_cls && dag_virtual(h1);
    ptr_sel = ptr_q[h1.idx];
    if (is_ind && (h1.ofs == OFS_INDEXED_BY_ACCUMULATOR_OPERAND)) begin
      // Signed index, pointer itself left alone
      eff2 = ptr_sel + {{4{req_in.acc[7]}}, req_in.acc};
    end else if (is_ind) begin
      eff2 = ptr_sel;
    end else begin
      eff2 = eff1;
    end
    h2 = dag_match(eff2);
    nested = is_ind && dag_virtual(h2);
    ptr_byte = h2.hit && (h2.ofs <= OFS_HIGH);
    // A result bound for the accumulator never lands in the pointer
    self_wr = is_ind && req_in.write && to_file && ptr_byte
              && (h2.idx == h1.idx);
    internal = ptr_byte || (eff2 == BSR_ADDR);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Destination routing

  always_comb begin
    to_acc = 1'b0;
    to_file = 1'b0;
    case (req_in.cls)
      CLS_BYTE: begin
        to_file = req_in.opcode[D_BIT];
        to_acc = !req_in.opcode[D_BIT];
      end
      CLS_BIT, CLS_FULL_MOVE: begin
        to_file = !req_in.implicit_acc;
        to_acc = req_in.implicit_acc;
      end
      CLS_INHERENT, CLS_LITERAL: begin
        to_acc = req_in.implicit_acc || (req_in.cls == CLS_LITERAL);
      end
      default: begin
        to_acc = 1'b0;
      end
    endcase
    file_wr = req_in.valid && req_in.write && to_file && !nested;
    rd_req = req_in.valid && !req_in.write && mem_cls;
  end

  always_comb begin
    if (nested) begin
      int_rdata = ZERO_BYTE;
    end else if (eff2 == BSR_ADDR) begin
      int_rdata = {4'h0, bsr_q};
    end else if (h2.ofs == OFS_HIGH) begin
      int_rdata = {4'h0, ptr_q[h2.idx][11:8]};
    end else begin
      int_rdata = ptr_q[h2.idx][7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pointer update controls

  always_comb begin
    for (int n = 0; n < NUM_PTR; n++) begin
      ptr_wr_lo[n] = file_wr && internal && h2.hit
                     && (h2.idx == 2'(n)) && (h2.ofs == OFS_LOW);
      ptr_wr_hi[n] = file_wr && internal && h2.hit
                     && (h2.idx == 2'(n)) && (h2.ofs == OFS_HIGH);
      // Only the closing access of an instruction moves the pointer
      ptr_inc[n] = is_ind && req_in.last && !self_wr
                   && (h1.idx == 2'(n)) && (h1.ofs == OFS_POSTINC);
      ptr_dec[n] = is_ind && req_in.last && !self_wr
                   && (h1.idx == 2'(n)) && (h1.ofs == OFS_POSTDEC);
    end
  end

  always_ff @(posedge clk_in) begin
    for (int n = 0; n < NUM_PTR; n++) begin
      if (sys_rst_in) begin
        ptr_q[n] <= PTR_RST;
      end else if (ptr_wr_lo[n]) begin
        ptr_q[n][7:0] <= req_in.wdata;
      end else if (ptr_wr_hi[n]) begin
        ptr_q[n][11:8] <= req_in.wdata[3:0];
      end else if (ptr_inc[n]) begin
        ptr_q[n] <= ptr_q[n] + 12'h001;
      end else if (ptr_dec[n]) begin
        ptr_q[n] <= ptr_q[n] - 12'h001;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      bsr_q <= BSR_RST;
    end else if (file_wr && (eff2 == BSR_ADDR)) begin
      bsr_q <= req_in.wdata[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memory side, one cycle after the request

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      mem_addr_out <= 12'h000;
      mem_rd_out <= 1'b0;
      mem_wr_out <= 1'b0;
      mem_wdata_out <= 8'h00;
    end else begin
      mem_addr_out <= eff2;
      // Other special registers go out like any direct access
      mem_rd_out <= rd_req && !nested && !internal;
      mem_wr_out <= file_wr && !internal;
      mem_wdata_out <= req_in.wdata;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      acc_wr_out <= 1'b0;
      acc_wdata_out <= 8'h00;
    end else begin
      acc_wr_out <= req_in.valid && req_in.write && to_acc;
      acc_wdata_out <= req_in.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Literal, branch and inherent outputs

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      literal_valid_out <= 1'b0;
      literal_out <= 8'h00;
      target_valid_out <= 1'b0;
      target_out <= 20'h00000;
      global_op_out <= 1'b0;
    end else begin
      literal_valid_out <= req_in.valid && (req_in.cls == CLS_LITERAL);
      literal_out <= req_in.opcode[7:0];
      target_valid_out <= req_in.valid && (req_in.cls == CLS_BRANCH);
      target_out <= {req_in.ext[11:0], req_in.opcode[7:0]};
      global_op_out <= req_in.valid && (req_in.cls == CLS_INHERENT)
                       && !req_in.implicit_acc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read answer, two cycles after the request

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rsel_mem_q <= 1'b0;
      rsel_int_q <= 1'b0;
      int_data_q <= 8'h00;
    end else begin
      rsel_mem_q <= rd_req && !nested && !internal;
      rsel_int_q <= rd_req && (nested || internal);
      int_data_q <= int_rdata;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rd_valid_out <= 1'b0;
      rd_data_out <= 8'h00;
    end else begin
      rd_valid_out <= rsel_mem_q || rsel_int_q;
      rd_data_out <= rsel_int_q ? int_data_q : mem_rdata_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  logic [7:0]  chk_lsb;
  logic        chk_dir;
  logic [11:0] chk_ptr0;
  assign chk_lsb = req_in.opcode[7:0];
  assign chk_dir = req_in.valid && mem_cls && !is_ind && !internal;
  assign chk_ptr0 = ptr_q[0];

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  sequence nested_rd_s;
    rd_req && nested;
  endsequence

  sequence zero_answer_s;
    // Back to back reads allowed, so only the own answer slot is judged
    !mem_rd_out ##1 rd_valid_out && (rd_data_out == ZERO_BYTE);
  endsequence

  bank_prefix_a: assert property (
    chk_dir && !req_in.write && (req_in.cls == CLS_BYTE)
    && req_in.opcode[A_BIT]
    |=> mem_rd_out && (mem_addr_out == {$past(bsr_q), $past(chk_lsb)}))
    else $error("banked address not formed from bank select");

  access_map_a: assert property (
    chk_dir && (req_in.cls == CLS_BIT) && !req_in.opcode[A_BIT]
    |=> (mem_addr_out[11:8] == ($past(chk_lsb) < ACCESS_SPLIT
         ? ACCESS_LO_BANK : ACCESS_HI_BANK)))
    else $error("access bank mapping wrong");

  full_move_a: assert property (
    chk_dir && req_in.write && (req_in.cls == CLS_FULL_MOVE)
    && !req_in.implicit_acc
    |=> mem_wr_out && (mem_addr_out == $past(req_in.ext[11:0])))
    else $error("full move destination not taken from second word");

  dest_acc_a: assert property (
    req_in.valid && req_in.write && (req_in.cls == CLS_BYTE)
    && !req_in.opcode[D_BIT]
    |=> acc_wr_out && !mem_wr_out)
    else $error("destination bit 0 did not go to accumulator");

  nested_zero_a: assert property (
    nested_rd_s |=> zero_answer_s)
    else $error("nested indirect read did not return zero");

  nested_nop_a: assert property (
    req_in.valid && req_in.write && nested
    |=> !mem_wr_out && ($past(chk_ptr0) == chk_ptr0 || $past(ptr_inc[0])
         || $past(ptr_dec[0])))
    else $error("nested indirect write had an effect");

  post_inc_a: assert property (
    ptr_inc[0] |=> chk_ptr0 == $past(chk_ptr0) + 12'h001)
    else $error("pointer 0 did not post-increment");

  indexed_by_accumulator_operand_hold_a: assert property (
    is_ind && (h1.ofs == OFS_INDEXED_BY_ACCUMULATOR_OPERAND) && !(file_wr && internal)
    |=> ptr_q[$past(h1.idx)] == $past(ptr_q[h1.idx]))
    else $error("indexed access changed its pointer");

  self_write_a: assert property (
    self_wr && (h2.ofs == OFS_LOW)
    |=> ptr_q[$past(h2.idx)][7:0] == $past(req_in.wdata))
    else $error("write into own pointer not stored as is");

  branch_tgt_a: assert property (
    req_in.valid && (req_in.cls == CLS_BRANCH)
    |=> target_valid_out
        && (target_out[19:8] == $past(req_in.ext[11:0]))
        && (target_out[7:0] == $past(req_in.opcode[7:0])))
    else $error("branch target not presented");

  literal_pass_a: assert property (
    req_in.valid && (req_in.cls == CLS_LITERAL)
    |=> literal_valid_out && (literal_out == $past(req_in.opcode[7:0])))
    else $error("literal operand not presented");

  global_op_a: assert property (
    req_in.valid && (req_in.cls == CLS_INHERENT) && !req_in.implicit_acc
    |=> global_op_out && !mem_wr_out && !mem_rd_out)
    else $error("inherent op did not raise global strobe");

  indirect_addr_a: assert property (
    is_ind && (h1.ofs == OFS_INDIRECT_OPERAND) && file_wr && !internal
    |=> mem_wr_out && (mem_addr_out == ptr_q[$past(h1.idx)]))
    else $error("plain indirect write missed pointer address");

endmodule : dag_core

/* bench/dag_mem_model.sv */
// Behavioural data RAM and special register space behind the generator
`timescale 1ns/100ps
module dag_mem_model (
  input  wire logic        clk_in,
  input  wire logic [11:0] mem_addr_in,
  input  wire logic        mem_rd_in,
  input  wire logic        mem_wr_in,
  input  wire logic [7:0]  mem_wdata_in,
  output logic [7:0]       mem_rdata_out
);
  logic [7:0] ram_q [4096];
  logic [7:0] held_q;
  logic       rd_q;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_in) begin
    if (mem_wr_in) ram_q[mem_addr_in] <= mem_wdata_in;
    if (mem_rd_in) held_q <= ram_q[mem_addr_in];
    rd_q <= mem_rd_in;
  end

  // Outside a read and the cycle after it the bus flips, so a stale sample never passes
  always_comb begin
    if (mem_rd_in) mem_rdata_out = ram_q[mem_addr_in];
    else if (rd_q) mem_rdata_out = held_q;
    else mem_rdata_out = ~held_q;
  end
endmodule : dag_mem_model

/* bench/data_address_generation_tb.sv */
// Self-checking bench for the data address generator
`timescale 1ns/100ps
module data_address_generation_tb
  import dag_pkg::*;
();
  logic        clk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  dag_req_s    req_in = '0;
  logic [7:0]  mem_rdata;
  logic [11:0] mem_addr_out;
  logic        mem_rd_out, mem_wr_out, acc_wr_out;
  logic [7:0]  mem_wdata_out, acc_wdata_out, literal_out, rd_data_out;
  logic        literal_valid_out, target_valid_out, global_op_out;
  logic [19:0] target_out;
  logic        rd_valid_out;
  int          num_errors = 0;
  int          n_checks = 0;

  always #5 clk_in = ~clk_in;

  dag_core dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .req_in(req_in),
    .mem_rdata_in(mem_rdata), .mem_addr_out(mem_addr_out),
    .mem_rd_out(mem_rd_out), .mem_wr_out(mem_wr_out),
    .mem_wdata_out(mem_wdata_out), .acc_wr_out(acc_wr_out),
    .acc_wdata_out(acc_wdata_out), .literal_valid_out(literal_valid_out),
    .literal_out(literal_out), .target_valid_out(target_valid_out),
    .target_out(target_out), .global_op_out(global_op_out),
    .rd_valid_out(rd_valid_out), .rd_data_out(rd_data_out));

  dag_mem_model mem (.clk_in(clk_in), .mem_addr_in(mem_addr_out),
    .mem_rd_in(mem_rd_out), .mem_wr_in(mem_wr_out),
    .mem_wdata_in(mem_wdata_out), .mem_rdata_out(mem_rdata));

  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run

  task automatic chk(string nm, logic [19:0] exp, logic [19:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", nm, exp, got);
      num_errors++;
    end
  endtask : chk

  function automatic dag_req_s mk(dag_cls_e c, logic [15:0] op,
      logic [15:0] ext, logic w, logic imp, logic [7:0] acc, logic [7:0] wd);
    dag_req_s r;
    r = '0;
    r.valid = 1'b1;
    r.write = w;
    r.last = 1'b1;
    r.implicit_acc = imp;
    r.cls = c;
    r.opcode = op;
    r.ext = ext;
    r.acc = acc;
    r.wdata = wd;
    return r;
  endfunction : mk

  // One request, then look just after the answering edge has landed
  task automatic go(dag_req_s r);
    @(posedge clk_in);
    req_in <= r;
    @(posedge clk_in);
    req_in <= '0;
    #1;
  endtask : go

  // Access bank direct write (d=1, a=0) and read
  task automatic dw(logic [7:0] lsb, logic [7:0] wd);
    go(mk(CLS_BYTE, {8'h02, lsb}, 16'h0000, 1'b1, 1'b0, 8'h00, wd));
  endtask : dw

  task automatic dr(logic [7:0] lsb);
    go(mk(CLS_BYTE, {8'h00, lsb}, 16'h0000, 1'b0, 1'b0, 8'h00, 8'h00));
  endtask : dr

  task automatic wat(logic [11:0] a, logic [7:0] d);
    chk("mem_wr", 20'h1, mem_wr_out);
    chk("mem_addr", 20'(a), mem_addr_out);
    chk("mem_wdata", 20'(d), mem_wdata_out);
    chk("acc_wr", 20'h0, acc_wr_out);
  endtask : wat

  task automatic nomem();
    chk("mem_wr", 20'h0, mem_wr_out);
    chk("mem_rd", 20'h0, mem_rd_out);
  endtask : nomem

  // Memory read: strobe now, answer one edge later
  task automatic rat(logic [11:0] a, logic [7:0] d);
    chk("mem_rd", 20'h1, mem_rd_out);
    chk("mem_addr", 20'(a), mem_addr_out);
    @(posedge clk_in);
    #1;
    chk("rd_valid", 20'h1, rd_valid_out);
    chk("rd_data", 20'(d), rd_data_out);
  endtask : rat

  // Internally served read: no strobe, answer one edge later
  task automatic rin(logic [7:0] d);
    chk("mem_rd", 20'h0, mem_rd_out);
    @(posedge clk_in);
    #1;
    chk("rd_valid", 20'h1, rd_valid_out);
    chk("rd_data", 20'(d), rd_data_out);
  endtask : rin

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_modes();
    nomem();
    dr(8'he0);
    rin(8'h00);
    go(mk(CLS_INHERENT, 16'h0003, 16'h0000, 1'b0, 1'b0, 8'h00, 8'h00));
    chk("global_op", 20'h1, global_op_out);
    go(mk(CLS_INHERENT, 16'h0007, 16'h0000, 1'b1, 1'b1, 8'h00, 8'h66));
    chk("acc_wdata", 20'h66, {11'h0, global_op_out, acc_wdata_out});
    go(mk(CLS_LITERAL, 16'h005a, 16'h0000, 1'b1, 1'b1, 8'h00, 8'h00));
    chk("literal", 20'h15a, {literal_valid_out, literal_out});
    go(mk(CLS_BRANCH, 16'h0034, 16'h0abc, 1'b0, 1'b0, 8'h00, 8'h00));
    chk("target", 20'habc34, target_out);
    chk("target_valid", 20'h1, target_valid_out);
    $display("test modes done");
  endtask : t_modes

  task automatic t_direct();
    dw(8'he0, 8'h03);
    nomem();
    go(mk(CLS_BYTE, 16'h0345, 16'h0000, 1'b1, 1'b0, 8'h00, 8'h11));
    wat(12'h345, 8'h11);
    go(mk(CLS_BYTE, 16'h0245, 16'h0000, 1'b1, 1'b0, 8'h00, 8'h22));
    wat(12'h045, 8'h22);
    dw(8'h90, 8'h33);
    wat(12'hf90, 8'h33);
    go(mk(CLS_FULL_MOVE, 16'h0345, 16'h0123, 1'b1, 1'b0, 8'h00, 8'h44));
    wat(12'h123, 8'h44);
    go(mk(CLS_BYTE, 16'h0145, 16'h0000, 1'b1, 1'b0, 8'h00, 8'h55));
    chk("acc_wr", 20'h155, {mem_wr_out, acc_wr_out, acc_wdata_out});
    go(mk(CLS_BIT, 16'h0145, 16'h0000, 1'b1, 1'b0, 8'h00, 8'h5b));
    wat(12'h345, 8'h5b);
    go(mk(CLS_BIT, 16'h0145, 16'h0000, 1'b1, 1'b1, 8'h00, 8'h5c));
    chk("acc_wr", 20'h15c, {mem_wr_out, acc_wr_out, acc_wdata_out});
    go(mk(CLS_BYTE, 16'h0145, 16'h0000, 1'b0, 1'b0, 8'h00, 8'h00));
    rat(12'h345, 8'h5b);
    go(mk(CLS_FULL_MOVE, 16'h0123, 16'h0045, 1'b0, 1'b0, 8'h00, 8'h00));
    rat(12'h123, 8'h44);
    go(mk(CLS_BIT, 16'h0090, 16'h0000, 1'b0, 1'b0, 8'h00, 8'h00));
    rat(12'hf90, 8'h33);
    $display("test direct done");
  endtask : t_direct

  task automatic t_indirect();
    dw(8'he9, 8'hff);
    dw(8'hea, 8'h01);
    dr(8'hea);
    rin(8'h01);
    dw(8'hee, 8'h71);
    wat(12'h1ff, 8'h71);
    dw(8'hef, 8'h72);
    wat(12'h200, 8'h72);
    dw(8'hed, 8'h73);
    wat(12'h200, 8'h73);
    go(mk(CLS_BYTE, 16'h02eb, 16'h0000, 1'b1, 1'b0, 8'hff, 8'h74));
    wat(12'h1fe, 8'h74);
    dr(8'hef);
    rat(12'h1ff, 8'h71);
    $display("test indirect done");
  endtask : t_indirect

  task automatic t_special();
    dw(8'he9, 8'he7);
    dw(8'hea, 8'h0f);
    dr(8'hef);
    rin(8'h00);
    dw(8'hef, 8'h99);
    nomem();
    dr(8'he9);
    rin(8'he7);
    dw(8'hd9, 8'hd9);
    dw(8'hda, 8'h0f);
    dw(8'hdd, 8'h80);
    nomem();
    dr(8'hd9);
    rin(8'h80);
    dw(8'he9, 8'he0);
    dw(8'hef, 8'h05);
    nomem();
    go(mk(CLS_BYTE, 16'h0310, 16'h0000, 1'b1, 1'b0, 8'h00, 8'h06));
    wat(12'h510, 8'h06);
    $display("test special done");
  endtask : t_special

  // Mid-run reset must clear bank select and pointer 0 again
  task automatic t_reset();
    @(posedge clk_in);
    sys_rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    #1;
    nomem();
    dr(8'he0);
    rin(8'h00);
    dr(8'he9);
    rin(8'h00);
    $display("test reset done");
  endtask : t_reset

  ////////////////////////////////////////////////////////////////////////////
  // A hang cannot outlive this bound
  initial begin
    repeat (100000) @(posedge clk_in);
    num_errors++;
    complete_run();
  end

  initial begin
    repeat (5) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    #1;
    t_modes();
    t_direct();
    t_indirect();
    t_special();
    t_reset();
    complete_run();
  end
endmodule : data_address_generation_tb
